// >>> sccfg_top.sv
// module: system control and offset calibration registers on wishbone
//
// Local design decision: the Wishbone register port.
`timescale 1ns/1ns

// Summary of operation
// - three-bit monitor select in bits 7:5; zero turns monitoring off
// - code one shorts amplifier inputs to mid-supply, inputs detached
// - code two routes temperature sensor; host must enable amplifier
// - codes three and four measure analog and digital supply over four
// - codes five to seven enable burn-out currents 0.2, 1, 10 uA
// - supply monitor codes override programmed gain with gain of one
// - mid, temperature and supply codes open all input mux switches
// - bits 4:3 pick calibration average of 1, 4, 8 or 16 samples
// - reset leaves sample code two, all other control bits zero
// - bit two enables serial timeout, cleared at reset
// - bit one appends a check byte after each result
// - check byte covers the result and status byte when present
// - bit zero prepends a status byte to each result
// - low offset byte is read-write, reset to zero
// - offset value is 24 bits over three consecutive registers
module sccfg_top (
    // clock and reset
    input  wire logic                 clk_i,
    input  wire logic                 rst_i,
    // wishbone slave
    input  wire logic                 cyc_i,
    input  wire logic                 stb_i,
    input  wire logic                 we_i,
    input  wire logic [7:0]           adr_i,
    input  wire logic [3:0]           sel_i,
    input  wire logic [31:0]          dat_i,
    output logic      [31:0]          dat_o,
    output logic                      ack_o,
    // amplifier settings from the core
    input  wire logic [2:0]           gain_req_i,
    input  wire logic [1:0]           amp_en_i,
    // decoded controls
    output sccfg_pkg::sccfg_analog_t  analog_o,
    output sccfg_pkg::sccfg_frame_t   frame_o,
    output logic      [23:0]          offset_correction_value_o
);
    logic [7:0]  system_control_r, system_control_nxt;
    logic [7:0]  ofs_r [3];
    logic [7:0]  ofs_nxt [3];
    logic [31:0] dat_r, dat_nxt;
    logic        ack_r, ack_nxt;
    logic [5:0]  idx;
    logic        req, wr;
    sccfg_pkg::sccfg_analog_t analog_c, analog_r;
    sccfg_pkg::sccfg_frame_t  frame_c, frame_r;

    assign idx = adr_i[7:2];
    assign req = cyc_i & stb_i & ~ack_r;
    assign wr  = req & we_i & sel_i[0];

    // combinational decode of the stored control byte
    sccfg_decode u_decode (
        .sysctl_i   (system_control_r),
        .gain_req_i (gain_req_i),
        .amp_en_i   (amp_en_i),
        .analog_o   (analog_c),
        .frame_o    (frame_c)
    );

    // register write next state
    always_comb begin
        system_control_nxt = system_control_r;
        for (int i = 0; i < 3; i++) begin
            ofs_nxt[i] = ofs_r[i];
        end
        if (wr && idx == sccfg_pkg::SCCFG_IDX_SYSCTL[5:0]) begin
            system_control_nxt = dat_i[7:0];
        end
        if (wr && idx == sccfg_pkg::SCCFG_IDX_OFS_LOW[5:0]) begin
            ofs_nxt[0] = dat_i[7:0];
        end
        if (wr && idx == sccfg_pkg::SCCFG_IDX_OFS_MID[5:0]) begin
            ofs_nxt[1] = dat_i[7:0];
        end
        if (wr && idx == sccfg_pkg::SCCFG_IDX_OFS_HIGH[5:0]) begin
            ofs_nxt[2] = dat_i[7:0];
        end
    end

    // read mux and single-cycle ack
    always_comb begin
        ack_nxt = req;
        dat_nxt = sccfg_pkg::SCCFG_UNMAPPED;
        if (req && !we_i) begin
            unique case (idx)
                sccfg_pkg::SCCFG_IDX_SYSCTL[5:0]:
                    dat_nxt = {24'h0, system_control_r};
                sccfg_pkg::SCCFG_IDX_OFS_LOW[5:0]:
                    dat_nxt = {24'h0, ofs_r[0]};
                sccfg_pkg::SCCFG_IDX_OFS_MID[5:0]:
                    dat_nxt = {24'h0, ofs_r[1]};
                sccfg_pkg::SCCFG_IDX_OFS_HIGH[5:0]:
                    dat_nxt = {24'h0, ofs_r[2]};
                default:
                    dat_nxt = sccfg_pkg::SCCFG_UNMAPPED;
            endcase
        end
    end

    // state registers
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            system_control_r <= sccfg_pkg::SCCFG_RST_SYSCTL;
            for (int i = 0; i < 3; i++) begin
                ofs_r[i] <= sccfg_pkg::SCCFG_RST_OFS;
            end
            dat_r    <= '0;
            ack_r    <= 1'b0;
            analog_r <= '0;
            frame_r  <= '0;
        end else begin
            system_control_r <= system_control_nxt;
            for (int i = 0; i < 3; i++) begin
                ofs_r[i] <= ofs_nxt[i];
            end
            dat_r    <= dat_nxt;
            ack_r    <= ack_nxt;
            analog_r <= analog_c;
            frame_r  <= frame_c;
        end
    end

    // outputs straight from flops
    assign dat_o    = dat_r;
    assign ack_o    = ack_r;
    assign analog_o = analog_r;
    assign frame_o  = frame_r;
    assign offset_correction_value_o = {ofs_r[2], ofs_r[1],
                                        ofs_r[0]};
endmodule // sccfg_top

// >>> sccfg_pkg.sv
// package: register map, field layout and decode constants
package sccfg_pkg;

    // register indices (byte address is four times the index)
    localparam logic [7:0] SCCFG_IDX_SYSCTL  = 8'h09;
    localparam logic [7:0] SCCFG_IDX_OFS_LOW = 8'h0A;
    localparam logic [7:0] SCCFG_IDX_OFS_MID = 8'h0B;
    localparam logic [7:0] SCCFG_IDX_OFS_HIGH = 8'h0C;

    // reset values
    localparam logic [7:0] SCCFG_RST_SYSCTL = 8'h10;
    localparam logic [7:0] SCCFG_RST_OFS    = 8'h00;

    // system control field positions
    localparam int SCCFG_MON_MSB    = 7;
    localparam int SCCFG_MON_LSB    = 5;
    localparam int SCCFG_CAVG_MSB   = 4;
    localparam int SCCFG_CAVG_LSB   = 3;
    localparam int SCCFG_TMO_BIT    = 2;
    localparam int SCCFG_CRC_BIT    = 1;
    localparam int SCCFG_STAT_BIT   = 0;

    // monitor codes
    localparam logic [2:0] SCCFG_MON_OFF   = 3'h0;
    localparam logic [2:0] SCCFG_MON_MID   = 3'h1;
    localparam logic [2:0] SCCFG_MON_TEMP  = 3'h2;
    localparam logic [2:0] SCCFG_MON_ASUP  = 3'h3;
    localparam logic [2:0] SCCFG_MON_DSUP  = 3'h4;
    localparam logic [2:0] SCCFG_MON_BO02  = 3'h5;
    localparam logic [2:0] SCCFG_MON_BO1   = 3'h6;
    localparam logic [2:0] SCCFG_MON_BO10  = 3'h7;

    // amplifier
    localparam logic [2:0] SCCFG_GAIN_ONE  = 3'h0;
    localparam logic [2:0] SCCFG_TEMP_GAIN_MAX = 3'h2;
    localparam logic [1:0] SCCFG_AMP_EN_ON = 2'h1;

    // burn-out current levels
    localparam logic [1:0] SCCFG_BO_OFF = 2'h0;
    localparam logic [1:0] SCCFG_BO_02  = 2'h1;
    localparam logic [1:0] SCCFG_BO_1   = 2'h2;
    localparam logic [1:0] SCCFG_BO_10  = 2'h3;

    // calibration sample counts per code
    localparam logic [4:0] SCCFG_CNT_0 = 5'h01;
    localparam logic [4:0] SCCFG_CNT_1 = 5'h04;
    localparam logic [4:0] SCCFG_CNT_2 = 5'h08;
    localparam logic [4:0] SCCFG_CNT_3 = 5'h10;

    // frame lengths in bytes: 3 data, +1 status, +1 check
    localparam logic [2:0] SCCFG_DATA_BYTES = 3'h3;

    // bus reply for unmapped index
    localparam logic [31:0] SCCFG_UNMAPPED = 32'h0000_0000;

    // decoded analog routing control
    typedef struct packed {
        logic       mid_short;
        logic       temp_route;
        logic       asup_mon;
        logic       dsup_mon;
        logic       mux_open;
        logic       force_unity;
        logic [1:0] burnout_level;
        logic [2:0] gain_applied;
        logic       temp_setup_bad;
    } sccfg_analog_t;

    // decoded data framing control
    typedef struct packed {
        logic       timeout_en;
        logic       crc_en;
        logic       crc_covers_status;
        logic       status_prefix_enable;
        logic [2:0] frame_bytes;
        logic [4:0] cal_samples;
    } sccfg_frame_t;

endpackage : sccfg_pkg

// >>> sccfg_decode.sv
// module: decode of the system control byte into control outputs
`timescale 1ns/1ns
module sccfg_decode (
    // configuration in
    input  wire logic [7:0]           sysctl_i,
    input  wire logic [2:0]           gain_req_i,
    input  wire logic [1:0]           amp_en_i,
    // decoded controls out
    output sccfg_pkg::sccfg_analog_t  analog_o,
    output sccfg_pkg::sccfg_frame_t   frame_o
);
    logic [2:0] mon;
    logic [1:0] cavg;

    assign mon  = sysctl_i[sccfg_pkg::SCCFG_MON_MSB:sccfg_pkg::SCCFG_MON_LSB];
    assign cavg = sysctl_i[sccfg_pkg::SCCFG_CAVG_MSB:
                           sccfg_pkg::SCCFG_CAVG_LSB];

    // monitor source decode
    always_comb begin
        analog_o = '0;
        analog_o.mid_short  = (mon == sccfg_pkg::SCCFG_MON_MID);
        analog_o.temp_route = (mon == sccfg_pkg::SCCFG_MON_TEMP);
        analog_o.asup_mon   = (mon == sccfg_pkg::SCCFG_MON_ASUP);
        analog_o.dsup_mon   = (mon == sccfg_pkg::SCCFG_MON_DSUP);
        // switches open for mid, temp and supply codes
        analog_o.mux_open = analog_o.mid_short | analog_o.temp_route |
                            analog_o.asup_mon | analog_o.dsup_mon;
        analog_o.force_unity = analog_o.asup_mon | analog_o.dsup_mon;
        analog_o.gain_applied = analog_o.force_unity ?
            sccfg_pkg::SCCFG_GAIN_ONE : gain_req_i;
        // flag a temp setup the host got wrong
        analog_o.temp_setup_bad = analog_o.temp_route &&
            ((gain_req_i > sccfg_pkg::SCCFG_TEMP_GAIN_MAX) ||
             (amp_en_i != sccfg_pkg::SCCFG_AMP_EN_ON));
        unique case (mon)
            sccfg_pkg::SCCFG_MON_BO02:
                analog_o.burnout_level = sccfg_pkg::SCCFG_BO_02;
            sccfg_pkg::SCCFG_MON_BO1:
                analog_o.burnout_level = sccfg_pkg::SCCFG_BO_1;
            sccfg_pkg::SCCFG_MON_BO10:
                analog_o.burnout_level = sccfg_pkg::SCCFG_BO_10;
            default:
                analog_o.burnout_level = sccfg_pkg::SCCFG_BO_OFF;
        endcase
    end

    // framing decode
    always_comb begin
        frame_o = '0;
        frame_o.timeout_en = sysctl_i[sccfg_pkg::SCCFG_TMO_BIT];
        frame_o.crc_en     = sysctl_i[sccfg_pkg::SCCFG_CRC_BIT];
        frame_o.status_prefix_enable =
            sysctl_i[sccfg_pkg::SCCFG_STAT_BIT];
        frame_o.crc_covers_status = frame_o.crc_en &
            frame_o.status_prefix_enable;
        frame_o.frame_bytes = sccfg_pkg::SCCFG_DATA_BYTES +
            {2'h0, frame_o.status_prefix_enable} +
            {2'h0, frame_o.crc_en};
        unique case (cavg)
            2'h0: frame_o.cal_samples = sccfg_pkg::SCCFG_CNT_0;
            2'h1: frame_o.cal_samples = sccfg_pkg::SCCFG_CNT_1;
            2'h2: frame_o.cal_samples = sccfg_pkg::SCCFG_CNT_2;
            2'h3: frame_o.cal_samples = sccfg_pkg::SCCFG_CNT_3;
        endcase
    end
endmodule // sccfg_decode

// >>> sccfg_sva.sv
// checker: bus handshake and decode relations of the control registers
`timescale 1ns/1ns
module sccfg_sva (
    // clock, reset and bus
    input wire logic        clk_i, rst_i, cyc_i, stb_i, we_i, ack_o,
    input wire logic [7:0]  adr_i,
    input wire logic [3:0]  sel_i,
    input wire logic [31:0] dat_i, dat_o,
    // core settings and decoded outputs
    input wire logic [2:0]  gain_req_i,
    input wire logic [1:0]  amp_en_i,
    input wire sccfg_pkg::sccfg_analog_t analog_o,
    input wire sccfg_pkg::sccfg_frame_t  frame_o,
    input wire logic [23:0] offset_correction_value_o
);
    localparam logic [4:0] CNT [4] = '{5'h01, 5'h04, 5'h08, 5'h10};
    logic take;
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);
    // byte write taken this edge
    assign take = cyc_i && stb_i && !ack_o && we_i && sel_i[0];
    ack_ans_a: assert property (cyc_i && stb_i && !ack_o |=> ack_o)
        else $error("request not acknowledged");
    ack_pulse_a: assert property (ack_o |=> !ack_o)
        else $error("ack held too long");
    rd_zero_a: assert property (
        dat_o[31:8] == 24'h0 && (ack_o || !dat_o))
        else $error("read data outside ack");
    mux_open_a: assert property (
        !$past(rst_i) |-> analog_o.mux_open == (analog_o.mid_short
        || analog_o.temp_route || analog_o.asup_mon || analog_o.dsup_mon))
        else $error("mux state wrong");
    mux_wr_a: assert property (
        take && adr_i == 8'h24 |-> ##2 analog_o.mux_open ==
        ($past(dat_i[7:5], 2) != 3'h0 && $past(dat_i[7:5], 2) < 3'h5))
        else $error("mux not opened for monitor code");
    unity_gain_a: assert property (
        analog_o.asup_mon || analog_o.dsup_mon
        |-> analog_o.force_unity && analog_o.gain_applied == 3'h0)
        else $error("supply monitor gain not one");
    gain_track_a: assert property (
        !$past(rst_i) && !analog_o.force_unity
        |-> analog_o.gain_applied == $past(gain_req_i)) else $error("gain");
    temp_flag_a: assert property (
        !$past(rst_i) |-> analog_o.temp_setup_bad == (analog_o.temp_route
        && ($past(gain_req_i) > 3'h2 || $past(amp_en_i) != 2'h1)))
        else $error("temperature setup flag wrong");
    burn_excl_a: assert property (analog_o.burnout_level != 2'h0
        |-> !analog_o.mux_open) else $error("burn-out with mux open");
    frame_len_a: assert property (
        !$past(rst_i) |-> frame_o.frame_bytes ==
        3'h3 + 3'(frame_o.crc_en) + 3'(frame_o.status_prefix_enable)
        && frame_o.crc_covers_status == (frame_o.crc_en
        && frame_o.status_prefix_enable)) else $error("frame length");
    cal_wr_a: assert property (take && adr_i == 8'h24 |-> ##2
        frame_o.cal_samples == CNT[$past(dat_i[4:3], 2)])
        else $error("sample count wrong");
    ctl_wr_a: assert property (
        take && adr_i == 8'h24 |-> ##2
        {frame_o.timeout_en, frame_o.crc_en, frame_o.status_prefix_enable}
        == $past(dat_i[2:0], 2)) else $error("framing bits wrong");
    burn_wr_a: assert property (take && adr_i == 8'h24 |-> ##2
        analog_o.burnout_level == ($past(dat_i[7], 2) ?
        $past(dat_i[6:5], 2) : 2'h0)) else $error("burn-out level");
    ofs_wr_a: assert property (take && adr_i == 8'h28 |=>
        offset_correction_value_o[7:0] == $past(dat_i[7:0]))
        else $error("offset low byte");
endmodule // sccfg_sva
bind sccfg_top sccfg_sva chk (.clk_i, .rst_i, .cyc_i, .stb_i, .we_i,
    .ack_o, .adr_i, .sel_i, .dat_i, .dat_o, .gain_req_i, .amp_en_i,
    .analog_o, .frame_o, .offset_correction_value_o);

// >>> sccfg_host.sv
// model: host controller on the register bus with amplifier setup, legal at start
`timescale 1ns/1ns
module sccfg_host (
    // clock and bus answer
    input  wire logic        clk_i,
    input  wire logic        ack_i,
    input  wire logic [31:0] dat_i,
    // bus request
    output logic             cyc_o, stb_o, we_o,
    output logic [7:0]       adr_o,
    output logic [3:0]       sel_o,
    output logic [31:0]      dat_o,
    // amplifier setup, legal at start, set to any value by the amp task
    output logic [2:0]       gain_o,
    output logic [1:0]       amp_en_o
);
    // idle bus, gain four at most, amplifier on
    initial begin
        {cyc_o, stb_o, we_o} = 3'h0;
        adr_o = 8'h00;
        sel_o = 4'h0;
        dat_o = 32'h0;
        gain_o = 3'h2;
        amp_en_o = 2'h1;
    end
    // change the amplifier setup at once, without waiting for a clock edge
    task automatic amp(input logic [2:0] g, input logic [1:0] e);
        gain_o <= g;
        amp_en_o <= e;
    endtask
    // one classic cycle; stale data inverted once released
    task automatic xfer(input logic w, input logic [7:0] a,
        input logic [7:0] d, input logic s, output logic [31:0] q);
        @(posedge clk_i);
        {cyc_o, stb_o, we_o} <= {2'h3, w};
        adr_o <= a;
        sel_o <= {3'h0, s};
        dat_o <= {24'h0, d};
        do @(posedge clk_i); while (ack_i !== 1'b1);
        q = dat_i;
        {cyc_o, stb_o} <= 2'h0;
        dat_o <= ~{24'h0, d};
    endtask
endmodule // sccfg_host

// >>> tb.sv
// testbench: register bus and decode scenarios
`timescale 1ns/1ns
module tb;
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic cyc, stb, we, ack;
    logic [7:0] adr;
    logic [3:0] sel;
    logic [31:0] wd, rdat, q;
    logic [2:0] gain;
    logic [1:0] amp;
    logic [23:0] ofs;
    sccfg_pkg::sccfg_analog_t an;
    sccfg_pkg::sccfg_frame_t fr;
    int mismatches = 0;
    int checks_done = 0;
    int cycles = 0;
    initial forever #50 clk_i = ~clk_i;
    sccfg_host host (.clk_i, .ack_i(ack), .dat_i(rdat), .cyc_o(cyc),
        .stb_o(stb), .we_o(we), .adr_o(adr), .sel_o(sel), .dat_o(wd),
        .gain_o(gain), .amp_en_o(amp));
    sccfg_top dut (.clk_i, .rst_i, .cyc_i(cyc), .stb_i(stb), .we_i(we),
        .adr_i(adr), .sel_i(sel), .dat_i(wd), .dat_o(rdat), .ack_o(ack),
        .gain_req_i(gain), .amp_en_i(amp), .analog_o(an), .frame_o(fr),
        .offset_correction_value_o(ofs));
    // compare one value
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp) begin
            mismatches++;
            $display("mismatch at %0t: got %h want %h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        host.xfer(1'b1, a, d, 1'b1, q);
    endtask
    task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
        host.xfer(1'b0, a, 8'h00, 1'b1, q);
        chk(q, exp);
    endtask
    // reset, then defaults
    task automatic t_reset;
        @(posedge clk_i);
        rst_i <= 1'b1;
        repeat (4) @(posedge clk_i);
        rst_i <= 1'b0;
        rdchk(8'h24, 32'h10);
        rdchk(8'h28, 32'h0);
        rdchk(8'h30, 32'h0);
        chk(32'(fr.cal_samples), 32'h8);
        chk(32'({fr.timeout_en, fr.crc_en}), 32'h0);
        $display("reset test done");
    endtask
    // every sample code and monitor code
    task automatic t_codes;
        for (int c = 0; c < 4; c++) begin
            wr(8'h24, 8'(c << 3));
            rdchk(8'h24, 32'(c << 3));
            chk(32'(fr.cal_samples), 32'h1 << (c ? c + 1 : 0));
        end
        for (int m = 0; m < 8; m++) begin
            wr(8'h24, 8'(m << 5));
            rdchk(8'h24, 32'(m << 5));
            chk(32'({an.mid_short, an.temp_route, an.asup_mon, an.dsup_mon}),
                32'(m >= 1 && m <= 4 ? 8 >> (m - 1) : 0));
            chk(32'(an.mux_open), 32'(m >= 1 && m <= 4));
            chk(32'(an.burnout_level), 32'(m >= 5 ? m - 4 : 0));
            chk(32'({an.force_unity, an.gain_applied}),
                (m == 3 || m == 4) ? 32'h8 : 32'h2);
            chk(32'(an.temp_setup_bad), 32'h0);
        end
        $display("code test done");
    endtask
    // framing bits
    task automatic t_frame;
        for (int b = 0; b < 8; b++) begin
            wr(8'h24, 8'(b));
            rdchk(8'h24, 32'(b));
            chk(32'({fr.timeout_en, fr.crc_en, fr.status_prefix_enable}),
                32'(b));
            chk(32'(fr.crc_covers_status), 32'(b[1] & b[0]));
            chk(32'(fr.frame_bytes), 32'(3 + b[1] + b[0]));
        end
        $display("frame test done");
    endtask
    // offset bytes, masked write, unmapped place
    task automatic t_ofs;
        wr(8'h28, 8'hA5);
        wr(8'h2C, 8'h5A);
        wr(8'h30, 8'hC3);
        host.xfer(1'b1, 8'h28, 8'h00, 1'b0, q);
        wr(8'h3C, 8'hFF);
        rdchk(8'h28, 32'hA5);
        rdchk(8'h2C, 32'h5A);
        rdchk(8'h30, 32'hC3);
        rdchk(8'h3C, 32'h0);
        chk(32'(ofs), 32'hC35AA5);
        $display("offset test done");
    endtask
    // amplifier setup against temp flag and gain override
    task automatic t_amp;
        wr(8'h24, 8'h40);
        host.amp(3'h5, 2'h1);
        repeat (2) @(posedge clk_i);
        chk(32'(an.temp_setup_bad), 32'h1);
        chk(32'(an.gain_applied), 32'h5);
        host.amp(3'h2, 2'h0);
        repeat (2) @(posedge clk_i);
        chk(32'(an.temp_setup_bad), 32'h1);
        wr(8'h24, 8'h60);
        host.amp(3'h5, 2'h1);
        repeat (2) @(posedge clk_i);
        chk(32'({an.force_unity, an.gain_applied}), 32'h8);
        chk(32'(an.temp_setup_bad), 32'h0);
        host.amp(3'h2, 2'h1);
        $display("amplifier test done");
    endtask
    // verdict and end of run
    task automatic final_report;
        $display("checks %0d mismatches %0d", checks_done, mismatches);
        if (mismatches == 0 && checks_done > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask
    // hang guard
    always @(posedge clk_i) begin
        cycles++;
        if (cycles == 3000) begin
            mismatches++;
            final_report;
        end
    end
    initial begin
        t_reset;
        t_codes;
        t_frame;
        t_ofs;
        t_amp;
        t_reset;
        final_report;
    end
endmodule // tb
